// File: dv/dafp_host_model.sv
// Host side of the frame link: drives frame select, shift clock and command bits.
module dafp_host_model (
   // Link toward the port.
   output logic shiftClk,
   output logic frameSelN,
   output logic serialCmdIn,
   // Data and enables coming back.
   input wire logic serialOutA,
   input wire logic serialOutAOe,
   input wire logic serialOutB,
   input wire logic serialOutBOe
);
   timeunit 1ns;
   timeprecision 100ps;

   // Bit n holds the value launched by falling edge n; bit 0 is the frame start value.
   logic [63:0] bitsA;
   logic [63:0] bitsB;
   // High while each enable was high at frame start and at every rising edge of the frame.
   logic oeA;
   logic oeB;

   // The shift clock stands low and the frame select high between frames.
   // A short low pulse on frame select at power-up gives the link logic a clean rising edge to clear on.
   initial begin
      shiftClk = 1'b0;
      frameSelN = 1'b0;
      serialCmdIn = 1'b0;
      #1 frameSelN = 1'b1;
   end

   // One frame: the lead adds idle time before the first edge to act as a slow host.
   task automatic run_frame(input logic [15:0] cmd, input int edges, input int lead);
      bitsA = '0;
      bitsB = '0;
      frameSelN = 1'b0;
      #(30 + lead);
      oeA = serialOutAOe;
      oeB = serialOutBOe;
      for (int n = 1; n <= edges; n++) begin
         #7.5 shiftClk = 1'b1;
         bitsA[n-1] = serialOutA;
         bitsB[n-1] = serialOutB;
         oeA = oeA & serialOutAOe;
         oeB = oeB & serialOutBOe;
         // Command bits go out MSB first, then the line is held low.
         serialCmdIn = (n <= 16) ? cmd[16-n] : 1'b0;
         #7.5 shiftClk = 1'b0;
      end
      #7.5 bitsA[edges] = serialOutA;
      bitsB[edges] = serialOutB;
      // Frame select rises well after the last edge, then a gap before any next frame.
      #20 frameSelN = 1'b1;
      serialCmdIn = 1'b0;
      #30;
   endtask
endmodule // dafp_host_model

// File: dv/tb_top.sv
// Self-checking bench for the frame port with a host model on the link.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dafp_pkg::*;

   // Clock, reset and converter results.
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [WORD_W-1:0] adcDataA = 16'h0000;
   logic [WORD_W-1:0] adcDataB = 16'h0000;
   // Link wires and outputs.
   wire shiftClk, frameSelN, serialCmdIn;
   logic serialOutA, serialOutAOe, serialOutB, serialOutBOe, sampleHold;
   logic [CFG_W-1:0] cfgWord;
   logic [TRIM_W-1:0] trimA, trimB;
   // Expected register contents and counters.
   logic [CFG_W-1:0] expCfg = 12'h000;
   logic [TRIM_W-1:0] expTa = 9'h000, expTb = 9'h000;
   int fails = 0;
   int checksDone = 0;

   // The system clock toggles every half period.
   always #2 mclk = ~mclk;

   dafp_frame_port i_dut (.mclk(mclk), .rstn(rstn), .shiftClk(shiftClk), .frameSelN(frameSelN),
      .serialCmdIn(serialCmdIn), .serialOutA(serialOutA), .serialOutAOe(serialOutAOe),
      .serialOutB(serialOutB), .serialOutBOe(serialOutBOe), .adcDataA(adcDataA), .adcDataB(adcDataB),
      .sampleHold(sampleHold), .cfgWord(cfgWord), .trimA(trimA), .trimB(trimB));

   dafp_host_model i_host (.shiftClk(shiftClk), .frameSelN(frameSelN), .serialCmdIn(serialCmdIn),
      .serialOutA(serialOutA), .serialOutAOe(serialOutAOe), .serialOutB(serialOutB),
      .serialOutBOe(serialOutBOe));

   // Compares one value against its expectation.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checksDone++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Places a word MSB first starting at the given edge number.
   function automatic logic [63:0] place(input logic [15:0] w, input int first);
      place = '0;
      for (int k = 0; k < 16; k++) place[first+k] = w[15-k];
   endfunction

   // Runs a frame and checks that output A is released and low afterwards.
   task automatic frame(input logic [15:0] cmd, input int edges, input int lead);
      i_host.run_frame(cmd, edges, lead);
      check(64'(serialOutAOe), 64'h0);
      check(64'(serialOutA), 64'h0);
   endtask

   // Compares all three programmable registers with the expected copies.
   task automatic regs();
      check(64'(cfgWord), 64'(expCfg));
      check(64'(trimA), 64'(expTa));
      check(64'(trimB), 64'(expTb));
   endtask

   // Results come out on both lines from edge 16; zeros before and after.
   task automatic t_dual(input logic [15:0] a, input logic [15:0] b, input int edges, input int lead);
      @(posedge mclk);
      adcDataA <= a;
      adcDataB <= b;
      @(posedge mclk);
      // The stage holds early in the conversion and samples again well before edge sixteen.
      fork
         frame(16'h0000, edges, lead);
         begin
            #42 check(64'(sampleHold), 64'h1);
            #180 check(64'(sampleHold), 64'h0);
         end
      join
      check(i_host.bitsA, place(a, 16));
      check(i_host.bitsB, place(b, 16));
      check(64'(i_host.oeA & i_host.oeB), 64'h1);
      check(64'(sampleHold), 64'h0);
      $display("test dual done");
   endtask

   // Writes to each register take effect after a valid frame; trims use bits 11:3.
   task automatic t_write();
      frame(16'h8123, 32, 0);
      expCfg = 12'h123;
      frame(16'h9abf, 32, 0);
      expTa = 9'(12'habf >> 3);
      frame(16'ha55a, 32, 0);
      expTb = 9'(12'h55a >> 3);
      regs();
      $display("test write done");
   endtask

   // A frame one edge short leaves the registers and returns to sampling.
   task automatic t_short();
      frame(16'h8fff, 31, 0);
      regs();
      check(64'(sampleHold), 64'h0);
      // Two edges end the frame while the conversion still runs, so the hold must drop at once.
      frame(16'h8fff, 2, 0);
      regs();
      check(64'(sampleHold), 64'h0);
      $display("test short done");
   endtask

   // Every no-operation code leaves the registers alone with all twelve low bits set.
   task automatic t_nop();
      for (int c = 0; c < 16; c++) begin
         if (!(c inside {1, 2, 3, 8, 9, 10})) frame({4'(c), 12'hfff}, 32, 0);
      end
      regs();
      $display("test nop done");
   endtask

   // Readback of each register, with a trim write carried in the data frame.
   task automatic t_readback();
      logic [3:0] codes [3] = '{OP_RD_CFG, OP_RD_TRIM_A, OP_RD_TRIM_B};
      logic [15:0] word;
      for (int i = 0; i < 3; i++) begin
         word = (i == 0) ? {codes[i], expCfg} : {codes[i], (i == 1) ? expTa : expTb, 3'h0};
         frame({codes[i], 12'h000}, 48, 0);
         frame({OP_WR_TRIM_B, 4'(i), 8'hf8}, 48, 0);
         expTb = 9'({4'(i), 8'hf8} >> 3);
         check(i_host.bitsA, place(word, 1));
         check(i_host.bitsB, 64'h0);
         regs();
      end
      $display("test readback done");
   endtask

   // Single-output mode needs 48 edges and sends both results on line A.
   task automatic t_single();
      frame(16'h8400, 32, 0);
      expCfg = 12'h400;
      frame(16'h9000, 32, 0);
      regs();
      @(posedge mclk);
      adcDataA <= 16'h1e2d;
      adcDataB <= 16'hc3b4;
      @(posedge mclk);
      frame(16'h0000, 48, 0);
      check(i_host.bitsA, place(16'h1e2d, 16) | place(16'hc3b4, 32));
      check(64'(i_host.oeB), 64'h0);
      frame(16'h8000, 48, 0);
      expCfg = 12'h000;
      regs();
      $display("test single done");
   endtask

   // A reset in mid-run leaves single-output mode and clears every register.
   task automatic t_reset();
      frame(16'h8400, 32, 0);
      expCfg = 12'h400;
      regs();
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (10) @(posedge mclk);
      check(64'(serialOutAOe | serialOutBOe), 64'h0);
      rstn <= 1'b1;
      expCfg = 12'h000;
      expTa = 9'h000;
      expTb = 9'h000;
      @(posedge mclk);
      regs();
      $display("test reset done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence after ten cycles of reset.
   initial begin
      repeat (10) @(posedge mclk);
      check(64'(serialOutAOe | serialOutBOe), 64'h0);
      rstn <= 1'b1;
      @(posedge mclk);
      regs();
      t_dual(16'ha5c3, 16'h3c5a, 32, 0);
      t_dual(16'h8001, 16'h7ffe, 60, 40);
      t_write();
      t_short();
      t_nop();
      t_readback();
      t_single();
      t_reset();
      t_dual(16'h0ff0, 16'hf00f, 32, 0);
      wrap_up();
   end

   // A hang is cut short well beyond the expected run time.
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
endmodule // tb_top

// File: verilog/dafp_frame_port.sv
// Operation
// - Short frame discards any attempted write.
// - First sixteen input bits form the command.
// - New configuration applies only after validation.
// - Top four command bits select the operation.
// - Codes 3,1,2 read config, trim A, B.
// - Codes 8,9,A write config, trim A, B.
// - Code 0, B, and x1xx do nothing.
// - Next frame shifts register on A, zeros B.
// - Readback word carries selector in top bits.
// - Writes in readback frame govern next frame.
// - Config bits 11:10 pick mode and count.
// - Conversion ends within sixteen shift clock periods.
// - Reset leaves dual-output mode active.
// - Frame start drives zero during the conversion.
// - Dual mode launches MSB at edge sixteen.
// - Sampling resumes as soon as conversion ends.
// - Dual needs 32 edges; frame end releases outputs.
// - Registers update at the end of valid frames.
// - Short frame aborts and resumes sampling.
module dafp_frame_port
   import dafp_pkg::*;
#(
   parameter int CONV_NS = dafp_pkg::CONV_TIME_NS
) (
   // System clock and synchronous active-low reset.
   input wire logic mclk,
   input wire logic rstn,
   // Serial link from the host.
   input wire logic shiftClk,
   input wire logic frameSelN,
   input wire logic serialCmdIn,
   // Serial data outputs with their output enables.
   output logic serialOutA,
   output logic serialOutAOe,
   output logic serialOutB,
   output logic serialOutBOe,
   // Converter results and the sample-and-hold control.
   input wire logic [dafp_pkg::WORD_W-1:0] adcDataA,
   input wire logic [dafp_pkg::WORD_W-1:0] adcDataB,
   output logic sampleHold,
   // Programmable register contents.
   output logic [dafp_pkg::CFG_W-1:0] cfgWord,
   output logic [dafp_pkg::TRIM_W-1:0] trimA,
   output logic [dafp_pkg::TRIM_W-1:0] trimB
);
   import dafp_pkg::*;

   // Conversion length in system clock cycles, rounded down as a longest time.
   localparam int CONV_CYC_RAW = CONV_NS / MCLK_PERIOD_NS;
   localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
   localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);

   // The conversion counter is eight bits wide.
   if (CONV_CYC > 255) begin : g_bad_conv
      $error("Conversion time too long for the conversion counter.");
   end

   // Returns the bit of a word launched at edge e when its MSB launches at edge first, else zero.
   function automatic logic bitAt(input logic [WORD_W-1:0] w, input logic [EDGE_W-1:0] e,
                                  input logic [EDGE_W-1:0] first);
      logic [EDGE_W-1:0] off;
      off = e - first;
      bitAt = (e >= first) && (off < EDGE_W'(WORD_W)) ? w[4'hf - off[3:0]] : 1'b0;
   endfunction

   // Registers of the mclk domain, read by the link as frame-stable words.
   logic [CFG_W-1:0] cfg_q;
   logic [TRIM_W-1:0] trimA_q;
   logic [TRIM_W-1:0] trimB_q;
   logic [WORD_W-1:0] resA_q;
   logic [WORD_W-1:0] resB_q;
   logic [WORD_W-1:0] rbWord_q;
   logic rbSel_q;

   // Link domain state, clocked by falling shift clock edges.
   logic [EDGE_W-1:0] edgeCnt_q;
   logic [WORD_W-1:0] cmd_q;
   logic linkValid_q;

   // Output mode decode shared by both domains.
   wire logic singleMode = (cfg_q[MODE_HI:MODE_LO] == MODE_SINGLE);
   wire logic [EDGE_W-1:0] needEdges = singleMode ? NEED_SINGLE : NEED_DUAL;

   // Next edge count saturates one past the longest frame.
   wire logic [EDGE_W-1:0] edgeNext = (edgeCnt_q == EDGE_SAT) ? EDGE_SAT : edgeCnt_q + 6'h01;

   // Launch selection for each output at the edge now arriving.
   wire logic launchA = rbSel_q ? bitAt(rbWord_q, edgeNext, EDGE_RB_FIRST)
                        : (bitAt(resA_q, edgeNext, EDGE_A_FIRST)
                           | (singleMode & bitAt(resB_q, edgeNext, EDGE_B_SINGLE)));
   wire logic launchB = (rbSel_q | singleMode) ? 1'b0 : bitAt(resB_q, edgeNext, EDGE_A_FIRST);

   // Edge counter; frame select high clears it so every frame counts from zero.
   always_ff @(negedge shiftClk or posedge frameSelN) begin
      if (frameSelN) begin
         edgeCnt_q <= '0;
      end else begin
         edgeCnt_q <= edgeNext;
      end
   end

   // Validation level rises at the mode-selected edge and falls with frame select.
   always_ff @(negedge shiftClk or posedge frameSelN) begin
      if (frameSelN) begin
         linkValid_q <= 1'b0;
      end else if (edgeNext >= needEdges) begin
         linkValid_q <= 1'b1;
      end
   end

   // Serial outputs drive zero from frame start and launch bits on falling edges.
   always_ff @(negedge shiftClk or posedge frameSelN) begin
      if (frameSelN) begin
         serialOutA <= 1'b0;
         serialOutB <= 1'b0;
      end else begin
         serialOutA <= launchA;
         serialOutB <= launchB;
      end
   end

   // Command shifter takes the first sixteen bits, MSB first, then holds until the next frame.
   always_ff @(negedge shiftClk) begin
      if (!frameSelN && edgeCnt_q < EDGE_CMD_LAST) begin
         cmd_q <= {cmd_q[WORD_W-2:0], serialCmdIn};
      end
   end

   // Frame select and validation cross into mclk through two flip-flops each.
   logic frameSelS;
   logic linkValidS;
   logic frameSelPrev_q;

   dafp_sync #(.RESET_VAL(1'b1)) u_sync_sel (
      .mclk(mclk),
      .rstn(rstn),
      .asyncIn(frameSelN),
      .syncOut(frameSelS)
   );

   dafp_sync #(.RESET_VAL(1'b0)) u_sync_valid (
      .mclk(mclk),
      .rstn(rstn),
      .asyncIn(linkValid_q),
      .syncOut(linkValidS)
   );

   // Frame boundaries seen in the mclk domain.
   wire logic frameStart = frameSelPrev_q & ~frameSelS;
   wire logic frameEnd = ~frameSelPrev_q & frameSelS;

   // Sticky validation flag of the current frame.
   logic frameValid_q;
   wire logic validNow = frameValid_q | linkValidS;
   wire logic commit = frameEnd & validNow;
   wire logic abortEnd = frameEnd & ~validNow;

   // Command decode; the command word is stable once the frame has ended.
   wire logic [3:0] op = cmd_q[WORD_W-1:WORD_W-4];
   wire logic [CFG_W-1:0] payload = cmd_q[CFG_W-1:0];
   wire logic isRdCfg = (op == OP_RD_CFG);
   wire logic isRdTrimA = (op == OP_RD_TRIM_A);
   wire logic isRdTrimB = (op == OP_RD_TRIM_B);
   wire logic isRead = isRdCfg | isRdTrimA | isRdTrimB;
   wire logic isWrCfg = (op == OP_WR_CFG);
   wire logic isWrTrimA = (op == OP_WR_TRIM_A);
   wire logic isWrTrimB = (op == OP_WR_TRIM_B);
   // Any other code, including 0000, 1011 and x1xx, matches none of the above and does nothing.

   // Readback word: selector code on top, then the register aligned high.
   wire logic [TRIM_W-1:0] rbTrim = isRdTrimA ? trimA_q : trimB_q;
   wire logic [WORD_W-1:0] rbWordD = isRdCfg ? {op, cfg_q} : {op, rbTrim, TRIM_PAD};

   // Frame edge tracking and the validation flag; the set wins over the clear.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         frameSelPrev_q <= 1'b1;
         frameValid_q <= 1'b0;
      end else begin
         frameSelPrev_q <= frameSelS;
         if (linkValidS) begin
            frameValid_q <= 1'b1;
         end else if (frameStart) begin
            frameValid_q <= 1'b0;
         end
      end
   end

   // Programmable registers change only on the end of a validated frame.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg_q <= CFG_RESET;
         trimA_q <= TRIM_RESET;
         trimB_q <= TRIM_RESET;
      end else if (commit) begin
         if (isWrCfg) begin
            cfg_q <= payload;
         end
         if (isWrTrimA) begin
            trimA_q <= payload[CFG_W-1:CFG_W-TRIM_W];
         end
         if (isWrTrimB) begin
            trimB_q <= payload[CFG_W-1:CFG_W-TRIM_W];
         end
      end
   end

   // A valid read command arms readback for the next frame; any other frame end disarms it.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rbSel_q <= 1'b0;
         rbWord_q <= '0;
      end else if (frameEnd) begin
         rbSel_q <= commit & isRead;
         rbWord_q <= rbWordD;
      end
   end

   // Conversion timing on the internal clock; hold from frame start until done or aborted.
   logic [7:0] convCnt_q;
   wire logic convDone = sampleHold & (convCnt_q == CONV_LAST);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sampleHold <= 1'b0;
         convCnt_q <= '0;
      end else if (frameStart) begin
         sampleHold <= 1'b1;
         convCnt_q <= '0;
      end else if (convDone || frameEnd) begin
         sampleHold <= 1'b0;
      end else if (sampleHold) begin
         convCnt_q <= convCnt_q + 8'h01;
      end
   end

   // Results are taken when the conversion finishes, ahead of the sixteenth edge.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         resA_q <= '0;
         resB_q <= '0;
      end else if (convDone) begin
         resA_q <= adcDataA;
         resB_q <= adcDataB;
      end
   end

   // Output enables follow the synchronised frame select; B stays released in single mode.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         serialOutAOe <= 1'b0;
         serialOutBOe <= 1'b0;
      end else begin
         serialOutAOe <= ~frameSelS;
         serialOutBOe <= ~frameSelS & ~singleMode;
      end
   end

   // Register contents as outputs.
   assign cfgWord = cfg_q;
   assign trimA = trimA_q;
   assign trimB = trimB_q;

   // Named steps of a committed write.
   sequence s_validEnd;
      commit;
   endsequence

   // An aborted frame leaves every programmable register as it was.
   chk_abort_keeps_regs: assert property (@(posedge mclk) disable iff (!rstn)
      abortEnd |=> $stable(cfg_q) && $stable(trimA_q) && $stable(trimB_q))
      else $error("Register changed after an aborted frame.");

   // A valid config write lands one cycle after the frame end.
   chk_cfg_write: assert property (@(posedge mclk) disable iff (!rstn)
      s_validEnd ##0 isWrCfg |=> cfg_q == $past(payload))
      else $error("Config write not applied.");

   // No-operation codes leave the programmable registers unchanged.
   chk_nop_idle: assert property (@(posedge mclk) disable iff (!rstn)
      commit && !isWrCfg && !isWrTrimA && !isWrTrimB |=> $stable(cfg_q) && $stable(trimA_q) && $stable(trimB_q))
      else $error("No-operation code changed a register.");

   // Readback word carries the selector code.
   chk_rb_selector: assert property (@(posedge mclk) disable iff (!rstn)
      commit && isRead |=> rbSel_q && rbWord_q[WORD_W-1:WORD_W-4] == $past(op))
      else $error("Readback word lacks its selector.");

   // After reset the device is in dual mode with output A released.
   chk_reset_dual: assert property (@(posedge mclk)
      $rose(rstn) |-> cfg_q[MODE_HI:MODE_LO] == MODE_DUAL && !serialOutAOe)
      else $error("Reset did not select dual mode.");

   // Hold lasts no longer than the conversion time.
   chk_conv_bound: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(sampleHold) |-> ##[1:CONV_CYC] !sampleHold)
      else $error("Conversion overran its time.");

   // In dual mode, frame start drives both outputs on the next cycle.
   chk_start_drive: assert property (@(posedge mclk) disable iff (!rstn)
      frameStart && !singleMode |=> serialOutAOe && serialOutBOe)
      else $error("Outputs not driven at frame start.");

   // Frame end releases the outputs on the next cycle.
   chk_end_release: assert property (@(posedge mclk) disable iff (!rstn)
      frameEnd |=> !serialOutAOe && !serialOutBOe)
      else $error("Outputs not released at frame end.");

   // The edge counter never passes its saturation value.
   chk_edge_sat: assert property (@(negedge shiftClk) disable iff (frameSelN)
      edgeCnt_q <= EDGE_SAT)
      else $error("Edge counter passed saturation.");

   // Dual mode launches the A result MSB on edge sixteen.
   chk_dual_msb: assert property (@(negedge shiftClk) disable iff (frameSelN)
      !rbSel_q && !singleMode && edgeCnt_q == EDGE_A_FIRST |-> serialOutA == resA_q[WORD_W-1])
      else $error("MSB not launched on edge sixteen.");

   // During a readback frame output B stays zero.
   chk_rb_b_zero: assert property (@(negedge shiftClk) disable iff (frameSelN)
      rbSel_q |-> !serialOutB)
      else $error("Output B not zero in readback frame.");

endmodule // dafp_frame_port

// File: verilog/dafp_pkg.sv
// Shared constants of the dual converter serial frame port.
package dafp_pkg;

   // System clock period in nanoseconds.
   localparam int MCLK_PERIOD_NS = 4;

   // Longest conversion time in nanoseconds; the internal converter clock must finish before the sixteenth edge.
   localparam int CONV_TIME_NS = 160;

   // Width of the command word and of each conversion result.
   localparam int WORD_W = 16;

   // Width of the configuration word and of each reference trim value.
   localparam int CFG_W = 12;
   localparam int TRIM_W = 9;

   // Width of the shift clock falling edge counter.
   localparam int EDGE_W = 6;

   // Edge numbers that mark the points of a frame.
   localparam logic [EDGE_W-1:0] EDGE_CMD_LAST = 6'h10;
   localparam logic [EDGE_W-1:0] EDGE_RB_FIRST = 6'h01;
   localparam logic [EDGE_W-1:0] EDGE_A_FIRST = 6'h10;
   localparam logic [EDGE_W-1:0] EDGE_B_SINGLE = 6'h20;
   localparam logic [EDGE_W-1:0] EDGE_SAT = 6'h31;

   // Least falling edge counts that validate a frame in each output mode.
   localparam logic [EDGE_W-1:0] NEED_DUAL = 6'h20;
   localparam logic [EDGE_W-1:0] NEED_SINGLE = 6'h30;

   // Output mode field of the configuration word and its encodings.
   localparam int MODE_HI = 11;
   localparam int MODE_LO = 10;
   localparam logic [1:0] MODE_DUAL = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;

   // Reset values of the programmable registers.
   localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
   localparam logic [TRIM_W-1:0] TRIM_RESET = 9'h000;

   // Operation selector codes in the top four command bits.
   localparam logic [3:0] OP_RD_TRIM_A = 4'h1;
   localparam logic [3:0] OP_RD_TRIM_B = 4'h2;
   localparam logic [3:0] OP_RD_CFG = 4'h3;
   localparam logic [3:0] OP_WR_CFG = 4'h8;
   localparam logic [3:0] OP_WR_TRIM_A = 4'h9;
   localparam logic [3:0] OP_WR_TRIM_B = 4'ha;

   // Zero padding below the trim value in a trim readback word.
   localparam logic [2:0] TRIM_PAD = 3'h0;

endpackage : dafp_pkg

// File: verilog/dafp_sync.sv
// Two flip-flop synchroniser for a single level entering the mclk domain.
module dafp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and synchronous reset.
   input wire logic mclk,
   input wire logic rstn,
   // Asynchronous level and its synchronised copy.
   input wire logic asyncIn,
   output logic syncOut
);

   // The first stage is read by the second stage only.
   logic meta_q;

   // Both stages load the reset value while rstn is low.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         meta_q <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule // dafp_sync
